/* File: include/fcs_pkg.sv */
/*
  package for the flash checksum / security-set programmer controller.
  holds status codes, frame constants, wait defaults and the result classes.
  assumes the csi link and the device boot firmware exist outside.
*/
package fcs_pkg;
  // device status codes
  localparam logic [7:0] ST_ACK        = 8'h06;
  localparam logic [7:0] ST_PARAM_ERR  = 8'h05;
  localparam logic [7:0] ST_SUM_ERR    = 8'h07;
  localparam logic [7:0] ST_PROTECT    = 8'h10;
  localparam logic [7:0] ST_NACK       = 8'h15;
  localparam logic [7:0] ST_WRITE_ERR1 = 8'h1a;
  localparam logic [7:0] ST_VERIFY_ERR = 8'h1b;
  localparam logic [7:0] ST_WRITE_ERR2 = 8'h1c;
  localparam logic [7:0] ST_NONE       = 8'h00;
  // frame framing
  localparam logic [7:0] FR_SOH = 8'h01;
  localparam logic [7:0] FR_STX = 8'h02;
  localparam logic [7:0] FR_ETX = 8'h03;
  localparam logic [7:0] CMD_GET_SUM  = 8'hb0;
  localparam logic [7:0] CMD_SET_SEC  = 8'ha0;
  localparam logic [7:0] LEN_SUM_CMD  = 8'h07;
  localparam logic [7:0] LEN_SEC_CMD  = 8'h03;
  localparam logic [7:0] LEN_SEC_DATA = 8'h02;
  localparam logic [7:0] PARAM_ZERO   = 8'h00;
  localparam logic [7:0] FLAG_FORCE   = 8'hf0;
  localparam int         FRAME_MAX    = 12;
  localparam int         IDX_W        = 4;
  // spi bit clock: half period in system cycles
  localparam int         CLK_NS       = 40;
  localparam int         SCK_HALF_NS  = 160;
  localparam int         SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int         WAIT_W       = 24;
  // default waits in microseconds
  localparam int         DEF_GAP_US     = 100;
  localparam int         DEF_WAIT_US    = 100;
  localparam int         DEF_TMO_US     = 50000;
  localparam int         US_CYC         = 1000 / CLK_NS;
  // result classes
  typedef enum logic [2:0] {RES_NONE, RES_A, RES_B, RES_C, RES_D, RES_E} result_e;
endpackage

/* File: design/csi_byte_shifter.sv */
/*
  byte-wide serial shifter, msb first, full duplex, master side.
  assumes one clock domain; miso is synchronised here.
*/
`timescale 1ns/100ps
module csi_byte_shifter
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // byte request
  input  wire logic       START,
  input  wire logic [7:0] TX_BYTE,
  output logic            DONE,
  output logic [7:0]      RX_BYTE,
  // serial pins
  output logic            SCK,
  output logic            MOSI,
  input  wire logic       MISO
);
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [7:0] div_r;
  logic       busy_r;
  logic       miso_s1_r;
  logic       miso_s2_r;
  logic       smp_r;
  logic       tick;

  always_ff @(posedge CLK)
  begin
    miso_s1_r <= MISO;
    miso_s2_r <= miso_s1_r;
  end

  assign tick = busy_r && (div_r == 8'(SCK_HALF_CYC - 1));

  always_ff @(posedge CLK)
  begin
    if (RESET || !busy_r || tick)
      div_r <= '0;
    else
      div_r <= div_r + 8'h01;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      busy_r  <= 1'b0;
      SCK     <= 1'b1;
      sh_r    <= '0;
      smp_r   <= 1'b0;
      bit_r   <= '0;
      DONE    <= 1'b0;
      RX_BYTE <= '0;
    end
    else
    begin
      DONE <= 1'b0;
      if (START && !busy_r)
      begin
        busy_r <= 1'b1;
        sh_r   <= TX_BYTE;
        bit_r  <= '0;
      end
      else if (tick)
      begin
        // falling edge drives, rising edge samples; mosi must not move on the rise
        if (SCK)
        begin
          SCK <= 1'b0;
          // first fall of a byte keeps bit 7 on the line
          if (bit_r != 4'h0)
            sh_r <= {sh_r[6:0], smp_r};
        end
        else
        begin
          SCK   <= 1'b1;
          smp_r <= miso_s2_r;
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h7)
          begin
            busy_r  <= 1'b0;
            DONE    <= 1'b1;
            RX_BYTE <= {sh_r[6:0], miso_s2_r};
          end
        end
      end
    end
  end

  assign MOSI = sh_r[7];
endmodule

/* File: design/flash_sum_sec_ctrl.sv */
/*
  programmer-side sequencer for the checksum and security-set commands.
  assumes the device boot firmware answers on a csi link with busy line.
*/
// Summary of operation
// - wait the command gap after the last frame before sending a command
// - after checksum command wait, then fetch status within its time-out
// - checksum status: normal continues, abnormal ends B, none ends C
// - wait the range-dependent delay before receiving the checksum data frame
// - valid checksum data frame ends A, invalid ends D
// - checksum result is first payload byte high, second low
// - checksum command length 7 with start and end address bytes
// - security command: wait data delay, send flag and boot block frame
// - after security status wait, fetch status: normal on, abnormal D, none C
// - then wait verify, fetch status: normal A, abnormal E, none C
// - security command length 3, block and page parameters zero
// - force upper four bits of the security flag byte to one
// - device holds busy while processing; time-out if busy too long
// - no status frame within the limit is time-out class C
`timescale 1ns/100ps
module flash_sum_sec_ctrl
  import fcs_pkg::*;
#(
  parameter int GAP_CYC = DEF_GAP_US * US_CYC,
  parameter int TMO_CYC = DEF_TMO_US * US_CYC
)
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // user command
  input  wire logic              GO_SUM,
  input  wire logic              GO_SEC,
  input  wire logic [23:0]       START_ADDRESS_BYTES,
  input  wire logic [23:0]       END_ADDRESS_BYTES,
  input  wire logic [7:0]        SECURITY_FLAG_BYTE,
  input  wire logic [7:0]        BOOT_BLOCK,
  input  wire logic [WAIT_W-1:0] SUM_STATUS_WAIT,
  input  wire logic [WAIT_W-1:0] SUM_DATA_WAIT,
  input  wire logic [WAIT_W-1:0] SECURITY_DATA_WAIT,
  input  wire logic [WAIT_W-1:0] SECURITY_STATUS_WAIT,
  input  wire logic [WAIT_W-1:0] VERIFY_STATUS_WAIT,
  // user result
  output logic                   BUSY,
  output logic                   DONE,
  output result_e                RESULT,
  output logic [7:0]             LAST_STATUS,
  output logic [15:0]            SUM_VALUE,
  // device link
  output logic                   SCK,
  output logic                   MOSI,
  input  wire logic              MISO,
  input  wire logic              HANDSHAKE_BUSY_LINE
);
  typedef enum logic [3:0] {
    S_IDLE, S_GAP, S_SEND, S_WAIT, S_HS, S_RECV, S_EVAL, S_FINISH
  } state_e;
  typedef enum logic [2:0] {P_CMD, P_STAT1, P_DATA, P_STAT2, P_STAT3} phase_e;

  state_e            state_r;
  phase_e            phase_r;
  logic              is_sec_r;
  logic [WAIT_W-1:0] cnt_r;
  logic [7:0]        buf_r [FRAME_MAX];
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  last_r;
  logic              shift_go;
  logic              shift_done;
  logic [7:0]        shift_rx;
  logic              hs_s1_r;
  logic              hs_s2_r;
  logic [7:0]        sum_calc;

  // frame sum: two's complement of len plus body
  function automatic logic [7:0] frame_sum(input logic [7:0] b [FRAME_MAX], input logic [IDX_W-1:0] n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 1; i < FRAME_MAX; i++)
      if (i[IDX_W-1:0] <= n)
        s = s - b[i];
    return s;
  endfunction

  always_ff @(posedge CLK)
  begin
    hs_s1_r <= HANDSHAKE_BUSY_LINE;
    hs_s2_r <= hs_s1_r;
  end

  csi_byte_shifter u_shift (
    .CLK     (CLK),
    .RESET   (RESET),
    .START   (shift_go),
    .TX_BYTE ((state_r == S_SEND) ? buf_r[idx_r] : 8'h00),
    .DONE    (shift_done),
    .RX_BYTE (shift_rx),
    .SCK     (SCK),
    .MOSI    (MOSI),
    .MISO    (MISO)
  );

  assign shift_go = (state_r == S_SEND || state_r == S_RECV) && !shift_done;
  assign sum_calc = frame_sum(buf_r, last_r - 4'h2);
  assign BUSY     = (state_r != S_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_r     <= S_IDLE;
      phase_r     <= P_CMD;
      is_sec_r    <= 1'b0;
      cnt_r       <= '0;
      idx_r       <= '0;
      last_r      <= '0;
      DONE        <= 1'b0;
      RESULT      <= RES_NONE;
      LAST_STATUS <= ST_NONE;
      SUM_VALUE   <= '0;
      for (int i = 0; i < FRAME_MAX; i++)
        buf_r[i] <= '0;
    end
    else
    begin
      DONE <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (GO_SUM || GO_SEC)
          begin
            is_sec_r <= !GO_SUM;
            phase_r  <= P_CMD;
            cnt_r    <= WAIT_W'(GAP_CYC);
            state_r  <= S_GAP;
            buf_r[0] <= FR_SOH;
            if (GO_SUM)
            begin
              buf_r[1] <= LEN_SUM_CMD;
              buf_r[2] <= CMD_GET_SUM;
              buf_r[3] <= START_ADDRESS_BYTES[23:16];
              buf_r[4] <= START_ADDRESS_BYTES[15:8];
              buf_r[5] <= START_ADDRESS_BYTES[7:0];
              buf_r[6] <= END_ADDRESS_BYTES[23:16];
              buf_r[7] <= END_ADDRESS_BYTES[15:8];
              buf_r[8] <= END_ADDRESS_BYTES[7:0];
              last_r   <= 4'd10;
            end
            else
            begin
              buf_r[1] <= LEN_SEC_CMD;
              buf_r[2] <= CMD_SET_SEC;
              buf_r[3] <= PARAM_ZERO;
              buf_r[4] <= PARAM_ZERO;
              last_r   <= 4'd6;
            end
          end
        end
        S_GAP:
        begin
          // patch in the sum and trailer once the body is stable
          buf_r[last_r - 4'h1] <= sum_calc;
          buf_r[last_r]        <= FR_ETX;
          if (cnt_r == '0)
          begin
            idx_r   <= '0;
            state_r <= S_SEND;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        S_SEND:
        begin
          if (shift_done)
          begin
            if (idx_r == last_r)
            begin
              state_r <= S_WAIT;
              case (phase_r)
                P_CMD:   if (is_sec_r)
                         begin
                           phase_r <= P_DATA;
                           cnt_r   <= SECURITY_DATA_WAIT;
                           state_r <= S_GAP;
                           buf_r[0] <= FR_STX;
                           buf_r[1] <= LEN_SEC_DATA;
                           buf_r[2] <= SECURITY_FLAG_BYTE | FLAG_FORCE;
                           buf_r[3] <= BOOT_BLOCK;
                           last_r   <= 4'd5;
                         end
                         else
                         begin
                           phase_r <= P_STAT1;
                           cnt_r   <= SUM_STATUS_WAIT;
                         end
                P_DATA:  begin
                           phase_r <= P_STAT2;
                           cnt_r   <= SECURITY_STATUS_WAIT;
                         end
                default: cnt_r <= '0;
              endcase
            end
            else
              idx_r <= idx_r + 4'h1;
          end
        end
        S_WAIT:
        begin
          if (cnt_r == '0)
          begin
            cnt_r   <= WAIT_W'(TMO_CYC);
            state_r <= S_HS;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        S_HS:
        begin
          if (!hs_s2_r)
          begin
            idx_r   <= '0;
            last_r  <= (phase_r == P_CMD) ? 4'd6 : 4'd5;                  // P_CMD reused as data fetch
            state_r <= S_RECV;
          end
          else if (cnt_r == '0)
          begin
            RESULT  <= RES_C;
            state_r <= S_FINISH;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        S_RECV:
        begin
          if (shift_done)
          begin
            buf_r[idx_r] <= shift_rx;
            if (idx_r == last_r)
              state_r <= S_EVAL;
            else
              idx_r <= idx_r + 4'h1;
          end
        end
        S_EVAL:
        begin
          state_r <= S_FINISH;
          if (phase_r == P_CMD)
          begin
            // checksum data frame
            if (buf_r[0] == FR_STX && sum_calc == buf_r[5] && buf_r[6] == FR_ETX)
            begin
              SUM_VALUE <= {buf_r[2], buf_r[3]};
              RESULT    <= RES_A;
            end
            else
              RESULT <= RES_D;
          end
          else
          begin
            LAST_STATUS <= buf_r[2];
            if (buf_r[2] != ST_ACK)
              case (phase_r)
                P_STAT1: RESULT <= RES_B;
                P_STAT2: RESULT <= RES_D;
                default: RESULT <= RES_E;
              endcase
            else
              case (phase_r)
                P_STAT1: begin
                           phase_r <= P_CMD;
                           cnt_r   <= SUM_DATA_WAIT;
                           state_r <= S_WAIT;
                         end
                P_STAT2: begin
                           phase_r <= P_STAT3;
                           cnt_r   <= VERIFY_STATUS_WAIT;
                           state_r <= S_WAIT;
                         end
                default: RESULT <= RES_A;
              endcase
          end
        end
        S_FINISH:
        begin
          DONE    <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_done_has_result;
    @(posedge CLK) disable iff (RESET) DONE |-> RESULT != RES_NONE;
  endproperty
  a_done_has_result: assert property (p_done_has_result) else $error("done without result");

  property p_flag_forced;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_SEND && phase_r == P_DATA && idx_r == 4'd2) |-> buf_r[2][7:4] == 4'hf;
  endproperty
  a_flag_forced: assert property (p_flag_forced) else $error("flag upper bits not set");

  property p_timeout_c;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_HS && hs_s2_r && cnt_r == '0) |=> RESULT == RES_C ##1 DONE;
  endproperty
  a_timeout_c: assert property (p_timeout_c) else $error("busy time-out not class C");

  property p_sum_len;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_SEND && phase_r == P_CMD && !is_sec_r && idx_r == 4'd1) |-> buf_r[1] == LEN_SUM_CMD;
  endproperty
  a_sum_len: assert property (p_sum_len) else $error("checksum length wrong");

  property p_sec_len;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_SEND && phase_r == P_CMD && is_sec_r && idx_r == 4'd3) |-> buf_r[1] == LEN_SEC_CMD && buf_r[3] == PARAM_ZERO;
  endproperty
  a_sec_len: assert property (p_sec_len) else $error("security frame wrong");

  property p_abn_b;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_EVAL && phase_r == P_STAT1 && buf_r[2] != ST_ACK) |=> RESULT == RES_B;
  endproperty
  a_abn_b: assert property (p_abn_b) else $error("abnormal not class B");

  property p_verify_e;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_EVAL && phase_r == P_STAT3 && buf_r[2] != ST_ACK) |=> RESULT == RES_E ##1 DONE;
  endproperty
  a_verify_e: assert property (p_verify_e) else $error("verify fail not class E");

  property p_gap_first;
    @(posedge CLK) disable iff (RESET)
      (state_r == S_IDLE && (GO_SUM || GO_SEC)) |=> state_r == S_GAP [*2];
  endproperty
  a_gap_first: assert property (p_gap_first) else $error("command sent without gap");

  c_sum_ok:  cover property (@(posedge CLK) DONE && RESULT == RES_A && !is_sec_r);
  c_sec_ok:  cover property (@(posedge CLK) DONE && RESULT == RES_A && is_sec_r);
  c_timeout: cover property (@(posedge CLK) DONE && RESULT == RES_C);
endmodule

/* File: testbench/flash_dev_model.sv */
/*
  behavioural model of the device boot firmware on the serial link.
  assumes sck comes from the controller (idle high, data out on fall, in on rise).
*/
`timescale 1ns/100ps
module flash_dev_model
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial link
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  output logic             busy,
  // scenario controls
  input  wire logic        stall,
  input  wire logic        bad_data,
  input  wire logic [7:0]  sec_status,
  input  wire logic [7:0]  verify_status,
  input  wire logic [15:0] sum_word,
  output logic [15:0]      sec_seen
);
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int         cnt[$];
  int         left;
  int         nbit;
  int         bcnt;
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  logic       tog;
  logic       tog_d;

  initial
  begin
    miso = 1'b1;
    tog = 1'b0;
    left = 0;
    nbit = 0;
    sec_seen = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rx_sum(input int a, input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = a; i <= b; i++)
      s = s - rxq[i];
    return s;
  endfunction

  // queue one answer frame: stx, len, payload, sum, etx
  function automatic void put(input logic [7:0] len, input logic [7:0] p0, input logic [7:0] p1, input logic bad);
    logic [7:0] s;
    s = 8'h00 - len - p0 - p1;
    txq.push_back(FR_STX);
    txq.push_back(len);
    txq.push_back(p0);
    txq.push_back(p1);
    if (len == 8'h03)
      txq.push_back(8'h00);
    txq.push_back(bad ? ~s : s);
    txq.push_back(FR_ETX);
    cnt.push_back(int'(len) + 4);
  endfunction

  function automatic void arm();
    left = cnt.pop_front();
    tx_sr = txq.pop_front();
    tog = ~tog;
  endfunction

  function automatic void take(input logic [7:0] b);
    logic [7:0] st;
    int         n;
    rxq.push_back(b);
    n = rxq.size();
    if (n < 2 || n != int'(rxq[1]) + 4)
      return;
    if (rxq[n-1] !== FR_ETX)
      st = ST_NACK;
    else if (rxq[n-2] !== rx_sum(1, n - 3))
      st = ST_SUM_ERR;
    else if (rxq[0] == FR_STX)
      st = sec_status;
    else if (rxq[2] == CMD_SET_SEC)
      st = 8'hff;
    else if ({rxq[4][2:0], rxq[5]} != 11'h000 || {rxq[7][2:0], rxq[8]} != 11'h7ff)
      st = ST_PARAM_ERR;
    else
      st = ST_ACK;
    if (rxq[0] == FR_STX)
      sec_seen = {rxq[2], rxq[3]};
    if (st != 8'hff)
      put(8'h02, st, 8'h00, 1'b0);
    if (st == ST_ACK && rxq[0] == FR_SOH)
      put(8'h03, sum_word[15:8], sum_word[7:0], bad_data);
    if (st == ST_ACK && rxq[0] == FR_STX)
      put(8'h02, verify_status, 8'h00, 1'b0);
    rxq.delete();
    if (cnt.size() > 0)
      arm();
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sck)
  begin
    rx_sr = {rx_sr[6:0], mosi};
    tx_sr = {tx_sr[6:0], 1'b0};
    nbit++;
    if (nbit == 8)
    begin
      nbit = 0;
      if (left > 0)
      begin
        left--;
        if (left > 0)
          tx_sr = txq.pop_front();
        else if (cnt.size() > 0)
          arm();
      end
      else
        take(rx_sr);
    end
  end

  // idle data line keeps changing so a stale bit never reads as valid
  always @(negedge sck)
    miso <= (left > 0) ? tx_sr[7] : ~miso;

  always @(posedge clk)
  begin
    tog_d <= tog;
    if (reset)
    begin
      rxq.delete();
      txq.delete();
      cnt.delete();
      left = 0;
      nbit = 0;
    end
    if (tog != tog_d)
      bcnt <= 12;
    else if (bcnt > 0)
      bcnt <= bcnt - 1;
  end

  assign busy = stall | (tog != tog_d) | (bcnt != 0);
endmodule

/* File: testbench/flash_sum_sec_ctrl_tb.sv */
/*
  self-checking bench for the checksum / security-set sequencer.
  assumes the device model answers on the serial link and busy line.
*/
`timescale 1ns/100ps
module flash_sum_sec_ctrl_tb;
  import fcs_pkg::*;
  logic              clk;
  logic              reset;
  logic              go_sum;
  logic              go_sec;
  logic [23:0]       start_a;
  logic [23:0]       end_a;
  logic [7:0]        flag;
  logic [7:0]        boot;
  logic [WAIT_W-1:0] wt;
  logic              busy_o;
  logic              done;
  result_e           result;
  logic [7:0]        last_st;
  logic [15:0]       sum_val;
  logic              sck;
  logic              mosi;
  logic              miso;
  logic              hs;
  logic              stall;
  logic              bad_data;
  logic [7:0]        sec_st;
  logic [7:0]        ver_st;
  logic [15:0]       sec_seen;
  int                fail_count;
  int                check_count;

  flash_sum_sec_ctrl #(.GAP_CYC(20), .TMO_CYC(200)) i_flash_sum_sec_ctrl (
    .CLK(clk), .RESET(reset), .GO_SUM(go_sum), .GO_SEC(go_sec),
    .START_ADDRESS_BYTES(start_a), .END_ADDRESS_BYTES(end_a),
    .SECURITY_FLAG_BYTE(flag), .BOOT_BLOCK(boot),
    .SUM_STATUS_WAIT(wt), .SUM_DATA_WAIT(wt), .SECURITY_DATA_WAIT(wt),
    .SECURITY_STATUS_WAIT(wt), .VERIFY_STATUS_WAIT(wt),
    .BUSY(busy_o), .DONE(done), .RESULT(result), .LAST_STATUS(last_st), .SUM_VALUE(sum_val),
    .SCK(sck), .MOSI(mosi), .MISO(miso), .HANDSHAKE_BUSY_LINE(hs));

  flash_dev_model i_flash_dev_model (
    .clk(clk), .reset(reset), .sck(sck), .mosi(mosi), .miso(miso), .busy(hs),
    .stall(stall), .bad_data(bad_data), .sec_status(sec_st), .verify_status(ver_st),
    .sum_word(16'h3c81), .sec_seen(sec_seen));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t status got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkres(input result_e got, input result_e exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t class got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
  endtask

  // one sequence: pulse go, wait for done, judge class and status
  task automatic run(input logic sum, input result_e res, input logic [7:0] st);
    int n;
    @(negedge clk);
    go_sum = sum;
    go_sec = ~sum;
    @(negedge clk);
    go_sum = 1'b0;
    go_sec = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000)
    begin
      fail_count++;
      $display("[ERR] %0t sequence never finished", $time);
    end
    chkres(result, res);
    chk8(last_st, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sum();
    start_a = 24'h000800;
    end_a = 24'h001fff;
    run(1'b1, RES_A, ST_ACK);
    chk16(sum_val, 16'h3c81);
    start_a = 24'h000804;
    run(1'b1, RES_B, ST_PARAM_ERR);
    start_a = 24'h000800;
    end_a = 24'h001ffe;
    run(1'b1, RES_B, ST_PARAM_ERR);
    end_a = 24'h001fff;
    bad_data = 1'b1;
    run(1'b1, RES_D, ST_ACK);
    bad_data = 1'b0;
    $display("checksum tests done");
  endtask

  task automatic t_sec();
    logic [7:0] codes[5];
    codes = '{ST_PARAM_ERR, ST_SUM_ERR, ST_PROTECT, ST_WRITE_ERR1, ST_WRITE_ERR2};
    flag = 8'h05;
    boot = 8'h03;
    run(1'b0, RES_A, ST_ACK);
    chk16(sec_seen, 16'hf503);
    foreach (codes[i])
    begin
      sec_st = codes[i];
      run(1'b0, RES_D, codes[i]);
    end
    sec_st = ST_ACK;
    ver_st = ST_VERIFY_ERR;
    run(1'b0, RES_E, ST_VERIFY_ERR);
    ver_st = ST_ACK;
    $display("security tests done");
  endtask

  task automatic t_timeout();
    do_reset();
    stall = 1'b1;
    run(1'b1, RES_C, ST_NONE);
    run(1'b0, RES_C, ST_NONE);
    stall = 1'b0;
    do_reset();
    run(1'b1, RES_A, ST_ACK);
    $display("time-out tests done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(60000 * 40);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    reset = 1'b1;
    go_sum = 1'b0;
    go_sec = 1'b0;
    start_a = 24'h000000;
    end_a = 24'h0007ff;
    flag = 8'h00;
    boot = 8'h00;
    wt = 24'h000008;
    stall = 1'b0;
    bad_data = 1'b0;
    sec_st = ST_ACK;
    ver_st = ST_ACK;
    fail_count = 0;
    check_count = 0;
    do_reset();
    t_sum();
    t_sec();
    t_timeout();
    end_of_test();
  end
endmodule
